// ---- shared/prot_ind_cfg.svh ----
// Constants of the protection indicator and settings block
// Assumes inclusion by bare name from the package and the design file
// What this block does
// - One shared phase indicator, one earth indicator
// - Yellow when started, red when operated
// - Red stays latched until a reset request
// - Per-indicator soft bit selects yellow latching
// - Button or two remote commands clear latches
// - Indicator state never gates protection
// - After operation, light over-start current indicators
// - Internal fault lights alarm and drives relay
// - Fault code is red one plus three digits
// - Setting on three right digits, marker lit
// - Phase low stage: definite or inverse select
// - Earth stage: definite or inverse select
// - High start from three bits, range bit
// - All three select bits set disables high stage
// - High delay 50/150/300/500 ms by two bits
// - Switch group view shows the checksum
`ifndef PROT_IND_CFG_SVH
`define PROT_IND_CFG_SVH
`define PI_CLK_HZ 40000000
`define PI_HS_T0_MS 50
`define PI_HS_T1_MS 150
`define PI_HS_T2_MS 300
`define PI_HS_T3_MS 500
`define PI_MS_CYC (`PI_CLK_HZ / 1000)
// Front switch bit positions (index from 0)
`define PI_FS_HS_SEL_LO 0
`define PI_FS_RANGE 5
`define PI_FS_HS_T_LO 6
// Soft switch bit positions
`define PI_SS_LS_RANGE_LO 0
`define PI_SS_LS_INV 2
`define PI_SS_PH_YMAN 3
`define PI_SS_EF_YMAN 4
`define PI_SS_EF_RANGE_LO 5
`define PI_SS_EF_INV 7
// Display selector, fault lead digit and indicator reset codes
`define PI_SEL_CHECKSUM 4'h8
`define PI_FAULT_LEAD 4'h1
`define PI_IND_RESET 2'h0
`endif

// ---- shared/prot_ind_pkg.sv ----
// Types of the protection indicator and settings block
// Assumes the config header is on the include path
`include "prot_ind_cfg.svh"
package prot_ind_pkg;
    // Indicator colour
    typedef enum logic [1:0] {PI_OFF, PI_YELLOW, PI_RED} pi_colour_e;
    // Display ownership
    typedef enum logic [1:0] {PI_DSP_SET, PI_DSP_SUM, PI_DSP_FLT} pi_dsp_e;
    // Whole registered state
    typedef struct packed {
        logic ph_y;
        logic ph_r;
        logic ef_y;
        logic ef_r;
        logic [2:0] cur_ind;
        logic [1:0] ph_col;
        logic [1:0] ef_col;
        logic alarm;
        logic sup_relay;
        logic [3:0] alarm_dly;
        logic [3:0] d_lead;
        logic lead_red;
        logic [11:0] d_low;
        logic [3:0] marker;
        logic ls_inv;
        logic [1:0] ls_rng;
        logic ef_inv;
        logic [1:0] ef_rng;
        logic hs_dis;
        logic hs_low_rng;
        logic [2:0] hs_idx;
        logic [31:0] hs_dly;
    } pi_state_s;
endpackage

// ---- hw/prot_ind.sv ----
// Indicator latching, alarm display and switch-derived settings
// Assumes stage start/trip levels and values synchronous to CLK_SYS
`timescale 1ns/1ps
`default_nettype none
`include "prot_ind_cfg.svh"
module prot_ind
    import prot_ind_pkg::*;
#(
    parameter int ALARM_DELAY = 8,
    parameter logic [5:0] RANGE_MAP = 6'b10_01_00
) (
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic PH_START,
    input wire logic PH_TRIP,
    input wire logic EF_START,
    input wire logic EF_TRIP,
    input wire logic [2:0] OVER_START,
    input wire logic RESET_BUTTON,
    input wire logic REMOTE_CLEAR_CMD_A,
    input wire logic REMOTE_CLEAR_CMD_B,
    input wire logic INTERNAL_FAULT,
    input wire logic FAULT_CODE_VALID,
    input wire logic [11:0] FAULT_CODE,
    input wire logic [7:0] FRONT_SWITCH_GROUP,
    input wire logic [7:0] SOFT_SWITCH_GROUP,
    input wire logic [3:0] SETTING_SEL,
    input wire logic [11:0] SETTING_VALUE,
    input wire logic [11:0] SWITCH_CHECKSUM,
    output logic [1:0] PHASE_IND,
    output logic [1:0] EARTH_IND,
    output logic [2:0] CURRENT_IND,
    output logic INTERNAL_FAULT_ALARM,
    output logic SUPERVISION_RELAY,
    output logic [3:0] DISP_LEAD,
    output logic DISP_LEAD_RED,
    output logic [11:0] DISP_DIGITS,
    output logic [3:0] SETTING_MARKER,
    output logic LS_INVERSE,
    output logic [1:0] LS_RANGE,
    output logic EF_INVERSE,
    output logic [1:0] EF_RANGE,
    output logic HS_DISABLED,
    output logic HS_LOW_RANGE,
    output logic [2:0] HS_START_IDX,
    output logic [31:0] HS_DELAY_CYC
);
    localparam logic [31:0] HS_C0 = 32'(`PI_HS_T0_MS * `PI_MS_CYC);
    localparam logic [31:0] HS_C1 = 32'(`PI_HS_T1_MS * `PI_MS_CYC);
    localparam logic [31:0] HS_C2 = 32'(`PI_HS_T2_MS * `PI_MS_CYC);
    localparam logic [31:0] HS_C3 = 32'(`PI_HS_T3_MS * `PI_MS_CYC);

    // Elaboration checks on the parameters
    if (ALARM_DELAY < 1 || ALARM_DELAY > 15) begin : g_bad_delay
        $error("ALARM_DELAY must be 1 to 15");
    end
    // Range table entries must be distinct codes
    if (RANGE_MAP[1:0] == RANGE_MAP[3:2]) begin : g_bad_map_a
        $error("RANGE_MAP entries 0 and 1 collide");
    end
    if (RANGE_MAP[1:0] == RANGE_MAP[5:4]) begin : g_bad_map_b
        $error("RANGE_MAP entries 0 and 2 collide");
    end
    if (RANGE_MAP[3:2] == RANGE_MAP[5:4]) begin : g_bad_map_c
        $error("RANGE_MAP entries 1 and 2 collide");
    end

    // Range bits to range index through the table
    function automatic logic [1:0] map_range(input logic [1:0] bits);
        logic [1:0] r;
        r = 2'h0;
        for (int i = 0; i < 3; i++) begin
            if (RANGE_MAP[i*2 +: 2] == bits) begin
                r = 2'(i);
            end
        end
        return r;
    endfunction

    // Colour from latched start and operate flags
    function automatic logic [1:0] colour(input logic y, input logic r);
        if (r) begin
            return 2'(PI_RED);
        end else if (y) begin
            return 2'(PI_YELLOW);
        end
        return 2'(PI_OFF);
    endfunction

    pi_state_s st_r; // Registered state
    pi_state_s st_nxt; // Next state
    logic clr; // Any clear request
    logic ph_ym; // Phase yellow manual mode
    logic ef_ym; // Earth yellow manual mode
    logic [1:0] hs_t; // High delay select

    assign clr = RESET_BUTTON | REMOTE_CLEAR_CMD_A
        | REMOTE_CLEAR_CMD_B;
    assign ph_ym = SOFT_SWITCH_GROUP[`PI_SS_PH_YMAN];
    assign ef_ym = SOFT_SWITCH_GROUP[`PI_SS_EF_YMAN];
    assign hs_t = FRONT_SWITCH_GROUP[`PI_FS_HS_T_LO +: 2];

    // Next state; indicators only observe stages, never feed back
    always_comb begin
        st_nxt = st_r;
        // Start latches: manual mode holds, self mode follows; set wins
        st_nxt.ph_y = PH_START | (ph_ym & st_r.ph_y & ~clr);
        st_nxt.ef_y = EF_START | (ef_ym & st_r.ef_y & ~clr);
        // Operate latches held until clear; trip set wins
        st_nxt.ph_r = PH_TRIP | (st_r.ph_r & ~clr);
        st_nxt.ef_r = EF_TRIP | (st_r.ef_r & ~clr);
        // Shared phase and separate earth colours
        st_nxt.ph_col = colour(st_nxt.ph_y, st_nxt.ph_r);
        st_nxt.ef_col = colour(st_nxt.ef_y, st_nxt.ef_r);
        // Current indicators latched on operation
        if (PH_TRIP | EF_TRIP) begin
            st_nxt.cur_ind = st_r.cur_ind | OVER_START;
        end else if (clr) begin
            st_nxt.cur_ind = 3'h0;
        end
        // Alarm after a short delay, relay at the same moment
        if (!INTERNAL_FAULT) begin
            st_nxt.alarm_dly = 4'h0;
            st_nxt.alarm = 1'b0;
        end else if (st_r.alarm_dly == 4'(ALARM_DELAY)) begin
            st_nxt.alarm = 1'b1;
        end else begin
            st_nxt.alarm_dly = st_r.alarm_dly + 4'h1;
        end
        st_nxt.sup_relay = st_nxt.alarm;
        // Display ownership: fault code, checksum, or setting
        if (st_nxt.alarm && FAULT_CODE_VALID) begin
            st_nxt.d_lead = `PI_FAULT_LEAD;
            st_nxt.lead_red = 1'b1;
            st_nxt.d_low = FAULT_CODE;
            st_nxt.marker = 4'h0;
        end else if (SETTING_SEL == `PI_SEL_CHECKSUM) begin
            st_nxt.d_lead = 4'h0;
            st_nxt.lead_red = 1'b0;
            st_nxt.d_low = SWITCH_CHECKSUM;
            st_nxt.marker = SETTING_SEL;
        end else begin
            st_nxt.d_lead = 4'h0;
            st_nxt.lead_red = 1'b0;
            st_nxt.d_low = SETTING_VALUE;
            st_nxt.marker = SETTING_SEL;
        end
        // Characteristic and range selection
        st_nxt.ls_inv = SOFT_SWITCH_GROUP[`PI_SS_LS_INV];
        st_nxt.ls_rng = map_range(
            SOFT_SWITCH_GROUP[`PI_SS_LS_RANGE_LO +: 2]);
        st_nxt.ef_inv = SOFT_SWITCH_GROUP[`PI_SS_EF_INV];
        st_nxt.ef_rng = map_range(
            SOFT_SWITCH_GROUP[`PI_SS_EF_RANGE_LO +: 2]);
        // High-set start selection and disable
        st_nxt.hs_idx = FRONT_SWITCH_GROUP[`PI_FS_HS_SEL_LO +: 3];
        st_nxt.hs_low_rng = FRONT_SWITCH_GROUP[`PI_FS_RANGE];
        st_nxt.hs_dis = &FRONT_SWITCH_GROUP[`PI_FS_HS_SEL_LO +: 3];
        // High-set delay in cycles
        case (hs_t)
            2'h0: st_nxt.hs_dly = HS_C0;
            2'h1: st_nxt.hs_dly = HS_C1;
            2'h2: st_nxt.hs_dly = HS_C2;
            2'h3: st_nxt.hs_dly = HS_C3;
            default: st_nxt.hs_dly = HS_C0;
        endcase
    end

    // State register with synchronous reset
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign PHASE_IND = st_r.ph_col;
    assign EARTH_IND = st_r.ef_col;
    assign CURRENT_IND = st_r.cur_ind;
    assign INTERNAL_FAULT_ALARM = st_r.alarm;
    assign SUPERVISION_RELAY = st_r.sup_relay;
    assign DISP_LEAD = st_r.d_lead;
    assign DISP_LEAD_RED = st_r.lead_red;
    assign DISP_DIGITS = st_r.d_low;
    assign SETTING_MARKER = st_r.marker;
    assign LS_INVERSE = st_r.ls_inv;
    assign LS_RANGE = st_r.ls_rng;
    assign EF_INVERSE = st_r.ef_inv;
    assign EF_RANGE = st_r.ef_rng;
    assign HS_DISABLED = st_r.hs_dis;
    assign HS_LOW_RANGE = st_r.hs_low_rng;
    assign HS_START_IDX = st_r.hs_idx;
    assign HS_DELAY_CYC = st_r.hs_dly;

    // Phase trip then no clear keeps red
    sequence s_trip_held;
        PH_TRIP ##1 !clr;
    endsequence
    // Earth trip then no clear keeps red
    sequence s_ef_trip_held;
        EF_TRIP ##1 !clr;
    endsequence
    // Manual phase yellow lit, no clear pending
    sequence s_ph_man_hold;
        ph_ym && st_r.ph_y && !clr;
    endsequence
    // Manual earth yellow lit, no clear pending
    sequence s_ef_man_hold;
        ef_ym && st_r.ef_y && !clr;
    endsequence

    // Phase red held after the trip drops
    a_red_latch_hold: assert property (
        @(posedge CLK_SYS) disable iff (RESET)
        s_trip_held |=> PHASE_IND == 2'(PI_RED))
        else $error("phase red not held");
    // Earth red held after the trip drops
    a_ef_latch_hold: assert property (
        @(posedge CLK_SYS) disable iff (RESET)
        s_ef_trip_held |=> EARTH_IND == 2'(PI_RED))
        else $error("earth red not held");
    // Earth trip turns the earth indicator red
    a_red_on_trip: assert property (
        @(posedge CLK_SYS) disable iff (RESET)
        EF_TRIP |=> EARTH_IND == 2'(PI_RED))
        else $error("earth red missing on trip");
    // Phase trip turns the shared indicator red
    a_ph_red_trip: assert property (
        @(posedge CLK_SYS) disable iff (RESET)
        PH_TRIP |=> PHASE_IND == 2'(PI_RED))
        else $error("phase red missing on trip");
    // Phase start lights the shared indicator
    a_yellow_start: assert property (
        @(posedge CLK_SYS) disable iff (RESET)
        PH_START && !PH_TRIP && !st_r.ph_r
        |=> PHASE_IND != 2'(PI_OFF))
        else $error("phase yellow missing");
    // Earth start lights the earth indicator yellow
    a_ef_yellow: assert property (
        @(posedge CLK_SYS) disable iff (RESET)
        EF_START && !EF_TRIP && !st_r.ef_r
        |=> EARTH_IND == 2'(PI_YELLOW))
        else $error("earth yellow missing");
    // Self-reset phase yellow goes dark
    a_yellow_self: assert property (
        @(posedge CLK_SYS) disable iff (RESET)
        !ph_ym && !PH_START && !PH_TRIP && !st_r.ph_r
        |=> PHASE_IND == 2'(PI_OFF))
        else $error("self reset yellow stuck");
    // Self-reset earth yellow goes dark
    a_ef_self: assert property (
        @(posedge CLK_SYS) disable iff (RESET)
        !ef_ym && !EF_START && !EF_TRIP && !st_r.ef_r
        |=> EARTH_IND == 2'(PI_OFF))
        else $error("earth self reset yellow stuck");
    // Manual phase yellow survives the stage reset
    a_ph_manual: assert property (
        @(posedge CLK_SYS) disable iff (RESET)
        s_ph_man_hold |=> PHASE_IND != 2'(PI_OFF))
        else $error("manual phase yellow lost");
    // Manual earth yellow survives the stage reset
    a_ef_manual: assert property (
        @(posedge CLK_SYS) disable iff (RESET)
        s_ef_man_hold |=> EARTH_IND != 2'(PI_OFF))
        else $error("manual earth yellow lost");
    // Clear with no trip and no start darkens earth
    a_clear_red: assert property (
        @(posedge CLK_SYS) disable iff (RESET)
        clr && !EF_TRIP && !EF_START |=> EARTH_IND == 2'(PI_OFF))
        else $error("earth indicator not cleared");
    // Clear with no trip and no start darkens phase
    a_ph_clear: assert property (
        @(posedge CLK_SYS) disable iff (RESET)
        clr && !PH_TRIP && !PH_START |=> PHASE_IND == 2'(PI_OFF))
        else $error("phase indicator not cleared");
    // Operation latches the over-start pattern
    a_cur_latch: assert property (
        @(posedge CLK_SYS) disable iff (RESET)
        PH_TRIP || EF_TRIP
        |=> (CURRENT_IND & $past(OVER_START)) == $past(OVER_START))
        else $error("current indicator not latched");
    // Clear with no operation empties the pattern
    a_cur_clear: assert property (
        @(posedge CLK_SYS) disable iff (RESET)
        clr && !PH_TRIP && !EF_TRIP |=> CURRENT_IND == 3'h0)
        else $error("current indicator not cleared");
    // Relay follows the alarm in the same cycle
    a_alarm_relay: assert property (
        @(posedge CLK_SYS) disable iff (RESET)
        INTERNAL_FAULT_ALARM == SUPERVISION_RELAY)
        else $error("alarm and relay differ");
    // Alarm waits a few cycles after the fault
    a_alarm_delay: assert property (
        @(posedge CLK_SYS) disable iff (RESET)
        $rose(INTERNAL_FAULT) |-> !INTERNAL_FAULT_ALARM [*2])
        else $error("alarm too early");
    // Alarm drops once the fault is gone
    a_alarm_off: assert property (
        @(posedge CLK_SYS) disable iff (RESET)
        !INTERNAL_FAULT |=> !INTERNAL_FAULT_ALARM)
        else $error("alarm stuck after fault");
    // Fault code view has a red leading one
    a_fault_code: assert property (
        @(posedge CLK_SYS) disable iff (RESET)
        INTERNAL_FAULT_ALARM && $past(FAULT_CODE_VALID)
        |-> DISP_LEAD == 4'h1 && DISP_LEAD_RED)
        else $error("fault lead digit wrong");
    // Setting view shows value and marker
    a_setting_view: assert property (
        @(posedge CLK_SYS) disable iff (RESET)
        !RESET && !INTERNAL_FAULT && SETTING_SEL != `PI_SEL_CHECKSUM
        |=> DISP_DIGITS == $past(SETTING_VALUE)
        && SETTING_MARKER == $past(SETTING_SEL))
        else $error("setting view wrong");
    // Switch group view shows the checksum
    a_sum_view: assert property (
        @(posedge CLK_SYS) disable iff (RESET)
        !RESET && !INTERNAL_FAULT && SETTING_SEL == `PI_SEL_CHECKSUM
        |=> DISP_DIGITS == $past(SWITCH_CHECKSUM))
        else $error("checksum view wrong");
    // Low stage characteristic follows its bit
    a_ls_select: assert property (
        @(posedge CLK_SYS) disable iff (RESET)
        !RESET |=> LS_INVERSE == $past(SOFT_SWITCH_GROUP[`PI_SS_LS_INV]))
        else $error("low stage characteristic wrong");
    // Earth stage characteristic follows its bit
    a_ef_select: assert property (
        @(posedge CLK_SYS) disable iff (RESET)
        !RESET |=> EF_INVERSE == $past(SOFT_SWITCH_GROUP[`PI_SS_EF_INV]))
        else $error("earth characteristic wrong");
    // High start index and range follow the switches
    a_hs_select: assert property (
        @(posedge CLK_SYS) disable iff (RESET)
        !RESET |=> HS_LOW_RANGE == $past(FRONT_SWITCH_GROUP[`PI_FS_RANGE])
        && HS_START_IDX == $past(FRONT_SWITCH_GROUP[2:0]))
        else $error("high start selection wrong");
    // All three select bits set disables the stage
    a_hs_disable: assert property (
        @(posedge CLK_SYS) disable iff (RESET)
        &FRONT_SWITCH_GROUP[2:0] |=> HS_DISABLED)
        else $error("high stage not disabled");
    // Any other code keeps the stage working
    a_hs_enable: assert property (
        @(posedge CLK_SYS) disable iff (RESET)
        !RESET && !(&FRONT_SWITCH_GROUP[2:0]) |=> !HS_DISABLED)
        else $error("high stage wrongly disabled");
    // Longest high delay code
    a_hs_delay: assert property (
        @(posedge CLK_SYS) disable iff (RESET)
        hs_t == 2'h3 |=> HS_DELAY_CYC == 32'd20000000)
        else $error("high delay wrong");
    // Shortest high delay code
    a_hs_short: assert property (
        @(posedge CLK_SYS) disable iff (RESET)
        !RESET && hs_t == 2'h0 |=> HS_DELAY_CYC == 32'd2000000)
        else $error("short high delay wrong");
endmodule
`default_nettype wire

// ---- testbench/prot_ind_panel.sv ----
// Front panel reset button and remote clear command model
// Assumes the bench drives go and sel at the rising clock edge
`timescale 1ns/1ps
`default_nettype none
module prot_ind_panel (
    input wire logic go,
    input wire logic [1:0] sel,
    output logic button,
    output logic clr_a,
    output logic clr_b
);
    // One clear source per request, chosen by sel
    assign button = go && (sel == 2'h0);
    assign clr_a = go && (sel == 2'h1);
    assign clr_b = go && (sel == 2'h2);
endmodule
`default_nettype wire

// ---- testbench/prot_ind_test.sv ----
// Self-checking bench for the indicator and settings block
// Assumes the package is compiled first and the panel model is present
`timescale 1ns/1ps
`default_nettype none
module prot_ind_test;
    import prot_ind_pkg::*;
    localparam int AD = 3; // Short alarm delay
    logic clk, rst, ph_s, ph_t, ef_s, ef_t, flt, flt_v, go, btn, ca, cb;
    logic alarm, relay, lead_red, ls_inv, ef_inv, hs_dis, hs_low;
    logic [1:0] sel, ph_ind, ef_ind, ls_rng, ef_rng;
    logic [2:0] ovr, cur, hs_idx, isel;
    logic [3:0] dsel, lead, marker;
    logic [7:0] fsw, ssw;
    logic [11:0] fcode, sval, csum, digits;
    logic [31:0] hs_dly;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    int ms [4] = '{50, 150, 300, 500};
    // Clock at 40 MHz
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    prot_ind #(.ALARM_DELAY(AD)) uut (.CLK_SYS(clk), .RESET(rst),
        .PH_START(ph_s), .PH_TRIP(ph_t), .EF_START(ef_s), .EF_TRIP(ef_t),
        .OVER_START(ovr), .RESET_BUTTON(btn), .REMOTE_CLEAR_CMD_A(ca),
        .REMOTE_CLEAR_CMD_B(cb), .INTERNAL_FAULT(flt),
        .FAULT_CODE_VALID(flt_v), .FAULT_CODE(fcode),
        .FRONT_SWITCH_GROUP(fsw), .SOFT_SWITCH_GROUP(ssw),
        .SETTING_SEL(dsel), .SETTING_VALUE(sval), .SWITCH_CHECKSUM(csum),
        .PHASE_IND(ph_ind), .EARTH_IND(ef_ind), .CURRENT_IND(cur),
        .INTERNAL_FAULT_ALARM(alarm), .SUPERVISION_RELAY(relay),
        .DISP_LEAD(lead), .DISP_LEAD_RED(lead_red), .DISP_DIGITS(digits),
        .SETTING_MARKER(marker), .LS_INVERSE(ls_inv), .LS_RANGE(ls_rng),
        .EF_INVERSE(ef_inv), .EF_RANGE(ef_rng), .HS_DISABLED(hs_dis),
        .HS_LOW_RANGE(hs_low), .HS_START_IDX(hs_idx), .HS_DELAY_CYC(hs_dly));
    prot_ind_panel panel (.go(go), .sel(sel), .button(btn), .clr_a(ca),
        .clr_b(cb));
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One clear request from source k, outputs settled after
    task automatic clr(input logic [1:0] k);
        @(posedge clk) begin
            go <= 1'b1;
            sel <= k;
        end
        @(posedge clk) go <= 1'b0;
        #1;
    endtask
    // Verdict and end of run
    task automatic results;
        if (failures == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles >= 2000) begin
            failures++;
            results();
        end
    end
    // Main sequence
    initial begin
        {ph_s, ph_t, ef_s, ef_t, flt, flt_v, go} = 7'h00;
        {ovr, sel, fsw, ssw, dsel} = 25'h0;
        fcode = 12'h5a3;
        sval = 12'h123;
        csum = 12'h9c4;
        rst = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk) #1 chk(ph_ind, 0);
        // Operation latches red and the current pattern
        @(posedge clk) begin
            ph_t <= 1'b1;
            ovr <= 3'h5;
        end
        @(posedge clk) begin
            ph_t <= 1'b0;
            ovr <= 3'h0;
        end
        #1 chk(ph_ind, 2);
        chk(ef_ind, 0);
        @(posedge clk) #1 chk(ph_ind, 2);
        chk(cur, 5);
        // Clear while tripped is overridden, then clear by button
        @(posedge clk) ph_t <= 1'b1;
        clr(2'h1);
        chk(ph_ind, 2);
        @(posedge clk) ph_t <= 1'b0;
        clr(2'h0);
        chk(ph_ind, 0);
        chk(cur, 0);
        // Self-resetting yellow
        @(posedge clk) ph_s <= 1'b1;
        @(posedge clk) ph_s <= 1'b0;
        #1 chk(ph_ind, 1);
        @(posedge clk) #1 chk(ph_ind, 0);
        // Manual yellow on both indicators, cleared by command A
        @(posedge clk) begin
            {ph_s, ef_s} <= 2'h3;
            ssw <= 8'h18;
        end
        @(posedge clk) {ph_s, ef_s} <= 2'h0;
        repeat (2) @(posedge clk);
        #1 chk({ph_ind, ef_ind}, 4'h5);
        clr(2'h1);
        chk({ph_ind, ef_ind}, 4'h0);
        // Earth red, cleared by command B
        @(posedge clk) ef_t <= 1'b1;
        @(posedge clk) ef_t <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk({ph_ind, ef_ind}, 4'h2);
        chk(hs_dly, 32'd2000000);
        clr(2'h2);
        chk(ef_ind, 0);
        // Characteristic select bits, one stage at a time
        @(posedge clk) ssw <= 8'h05;
        @(posedge clk) #1 chk({ls_inv, ls_rng, ef_inv, ef_rng}, 6'h28);
        @(posedge clk) ssw <= 8'hc0;
        @(posedge clk) #1 chk({ls_inv, ls_rng, ef_inv, ef_rng}, 6'h06);
        // High-set delay, range, start index and disable
        for (int i = 0; i < 4; i++) begin
            isel = (i == 3) ? 3'h7 : 3'(i);
            @(posedge clk) fsw <= {i[1:0], i[0], 2'h0, isel};
            @(posedge clk) #1 chk(hs_dly, ms[i] * 40000);
            chk({hs_low, hs_idx}, {i[0], isel});
            chk(hs_dis, i == 3);
        end
        // Display selection
        @(posedge clk) dsel <= 4'h8;
        @(posedge clk) #1 chk(digits, csum);
        chk(marker, 4'h8);
        @(posedge clk) dsel <= 4'h1;
        @(posedge clk) #1 chk(digits, sval);
        chk(marker, 4'h1);
        // Internal fault alarm timing and fault code
        @(posedge clk) {flt, flt_v} <= 2'h3;
        repeat (AD) @(posedge clk);
        #1 chk({alarm, relay}, 2'h0);
        @(posedge clk) #1 chk({alarm, relay}, 2'h3);
        chk({lead_red, lead, digits}, {1'b1, 4'h1, fcode});
        results();
    end
endmodule
`default_nettype wire
